// >>> src/spcr_pkg.sv
package spcr_pkg;
  // Register addresses on the special-function bus
  localparam logic [7:0] ADDR_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_BUFFER = 8'h99;
  localparam logic [7:0] ADDR_SLAVE = 8'ha9;
  localparam logic [7:0] ADDR_MASK = 8'hb9;

  // Values after reset
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_BUFFER = 8'h00;
  localparam logic [7:0] RESET_SLAVE = 8'h00;
  localparam logic [7:0] RESET_MASK = 8'h00;

  // Serial control field positions
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_MULTI = 5;
  localparam int BIT_RX_EN = 4;
  localparam int BIT_TX9 = 3;
  localparam int BIT_RX9 = 2;
  localparam int BIT_TXDONE = 1;
  localparam int BIT_RXDONE = 0;

  // Rate dividers in system clocks
  localparam int M0_DIV_STD = 12;
  localparam int M0_DIV_X2 = 6;
  localparam int M2_DIV_STD = 64;
  localparam int M2_DIV_DBL = 32;
  localparam int OVERSAMPLE = 16;

  // Bit counts and sample points
  localparam logic [3:0] M0_BITS = 4'h8;
  localparam logic [3:0] FRAME8_BITS = 4'ha;
  localparam logic [3:0] FRAME9_BITS = 4'hb;
  localparam logic [3:0] DATA8_BITS = 4'h8;
  localparam logic [3:0] DATA9_BITS = 4'h9;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam int TX_FIFO_DEPTH = 32;

  typedef enum logic [1:0] {MODE_SHIFT, MODE_UART8, MODE_UART9_FIXED, MODE_UART9_VAR} spcr_mode_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} spcr_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_START, RX_DATA} spcr_rx_state_t;

  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spcr_sfr_req_t;

  typedef struct packed {
    logic en;
    logic [2:0] idx;
    logic val;
  } spcr_bit_wr_t;

  typedef struct packed {
    logic framingCheck;
    logic doubleRate;
    logic halfCycle;
  } spcr_clkcfg_t;
endpackage : spcr_pkg

// >>> src/spcr_tick.sv
`timescale 1ns/100ps
module spcr_tick
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire spcr_pkg::spcr_mode_t mode,
  input wire spcr_pkg::spcr_clkcfg_t clkCfg,
  input wire logic baudTick,
  output logic tick
);
  import spcr_pkg::*;

  localparam int CW = 6;

  logic [CW-1:0] divCnt_q, divCnt_d;
  logic [CW-1:0] divLast;
  logic baudHalf_q, baudHalf_d;
  logic tick_q, tick_d;

  // Half-bit tick in shift mode, 16x sample tick otherwise
  always_comb
  begin
    divLast = CW'(M2_DIV_STD / OVERSAMPLE - 1);
    if (mode == MODE_SHIFT)
    begin
      divLast = clkCfg.halfCycle ? CW'(M0_DIV_X2 / 2 - 1) : CW'(M0_DIV_STD / 2 - 1); // [RQ4]
    end
    else if (clkCfg.doubleRate)
    begin
      divLast = CW'(M2_DIV_DBL / OVERSAMPLE - 1); // [RQ5]
    end
    divCnt_d = (divCnt_q >= divLast) ? '0 : divCnt_q + 1'h1;
    baudHalf_d = baudHalf_q ^ baudTick;
    if (mode == MODE_SHIFT || mode == MODE_UART9_FIXED)
    begin
      tick_d = (divCnt_q >= divLast);
    end
    else
    begin
      tick_d = baudTick & (clkCfg.doubleRate | baudHalf_q);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCnt_q <= '0;
      baudHalf_q <= 1'h0;
      tick_q <= 1'h0;
    end
    else
    begin
      divCnt_q <= divCnt_d;
      baudHalf_q <= baudHalf_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : spcr_tick

// >>> src/spcr_fifo.sv
`timescale 1ns/100ps
module spcr_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  assign inReady = (count_q != (AW + 1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];

  always_comb
  begin
    push = inValid & inReady;
    pop = outValid & outReady;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    if (push)
    begin
      wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'h1;
    end
    if (pop)
    begin
      rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'h1;
    end
    count_d = count_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule : spcr_fifo

// >>> src/spcr_top.sv
`timescale 1ns/100ps
// Behaviour
// (RQ1) Control bit 7 is framing error if check select set, else mode-high bit.
// (RQ2) An invalid stop bit sets the framing error flag.
// (RQ3) Framing error stays set until software writes zero; good frames never clear it.
// (RQ4) Mode 0 shifts at clock/12, or clock/6 in half-cycle clock mode.
// (RQ5) Mode 2 sends 9-bit frames at clock/64, or clock/32 with double rate.
// (RQ6) In 9-bit modes the received ninth bit is copied into the ninth-bit flag.
// (RQ7) Transmit done sets after the eighth bit in mode 0, else at stop start.
// (RQ8) In mode 0 receive done sets at the end of the eighth bit.
// (RQ9) Software clears done flags by writing zero; hardware only sets them.
// (RQ10) Control, buffer, slave address and mask reset to zero; control is bit-writable.
// (RQ11) Address recognition is on while multiprocessor enable set, never in mode 0.
// (RQ12) With recognition on, receive done rises only for given or broadcast address.
// (RQ13) Given address is slave address with zero mask bits as don't-care.
// (RQ14) Broadcast address is slave address OR mask, zero bits don't-care.
// (RQ15) Mode bits 00, 01, 10, 11 select modes 0, 1, 2, 3.
// (RQ16) Buffer write starts a transmit, read gives last byte; receive needs enable.
module spcr_top
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire spcr_pkg::spcr_sfr_req_t sfrReq,
  input wire spcr_pkg::spcr_bit_wr_t bitWr,
  input wire spcr_pkg::spcr_clkcfg_t clkCfg,
  input wire logic baudTick,
  input wire logic rxdPin,
  output logic [7:0] sfrRdata,
  output logic txBufReady,
  output logic txd,
  output logic rxdDrive,
  output logic rxdDriveEn
);
  import spcr_pkg::*;

  logic [7:0] ctrl_q, ctrl_d, slave_q, slave_d, mask_q, mask_d, rxData_q, rxData_d;
  logic frameErr_q, frameErr_d;
  spcr_mode_t mode;
  logic tick, multiActive, givenHit, bcastHit;
  logic [7:0] rxByte, bcastMask;
  logic fifoPush, fifoReady, fifoValid, txStart;
  logic [7:0] fifoData;

  spcr_tx_state_t txState_q, txState_d;
  logic [10:0] txShift_q, txShift_d;
  logic [3:0] txBits_q, txBits_d, txOvs_q, txOvs_d;
  logic txHalf_q, txHalf_d, txLine_q, txLine_d, txBit0_q, txBit0_d, txOe_q, txOe_d;
  logic txDoneSet;

  spcr_rx_state_t rxState_q, rxState_d;
  logic [8:0] rxShift_q, rxShift_d;
  logic [3:0] rxIdx_q, rxIdx_d, rxOvs_q, rxOvs_d, rxDataBits;
  logic rxHalf_q, rxHalf_d, rxAccept, rxFrameErr, rxNinth, rxLoadNinth;

  logic rxdMeta_q, rxdSync_q, rxdPrev_q;
  logic [7:0] sfrRdata_q, sfrRdata_d;
  logic txBufReady_q, txBufReady_d, txd_q, txd_d, rxdDrive_q, rxdDriveEn_q;

  assign mode = spcr_mode_t'(ctrl_q[BIT_MODE_HI:BIT_MODE_LO]); // [RQ15]
  assign multiActive = ctrl_q[BIT_MULTI] && (mode != MODE_SHIFT); // [RQ11]
  assign rxByte = rxShift_q[7:0];
  assign givenHit = ((rxByte ^ slave_q) & mask_q) == 8'h00; // [RQ13]
  assign bcastMask = slave_q | mask_q;
  assign bcastHit = (rxByte & bcastMask) == bcastMask; // [RQ14]
  assign rxDataBits = (mode == MODE_UART8) ? DATA8_BITS : DATA9_BITS;
  assign fifoPush = sfrReq.wrEn && (sfrReq.addr == ADDR_BUFFER); // [RQ16]
  assign txStart = (txState_q == TX_IDLE) && fifoValid && tick // [RQ4] [RQ5]
    && !(mode == MODE_SHIFT && rxState_q != RX_IDLE);

  spcr_tick u_tick
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .mode(mode),
    .clkCfg(clkCfg),
    .baudTick(baudTick),
    .tick(tick)
  );

  spcr_fifo #(.WIDTH(8), .DEPTH(TX_FIFO_DEPTH)) u_txFifo
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inValid(fifoPush),
    .inReady(fifoReady),
    .inData(sfrReq.wdata),
    .outValid(fifoValid),
    .outReady(txStart),
    .outData(fifoData)
  );

  // Register file
  always_comb
  begin
    ctrl_d = ctrl_q;
    frameErr_d = frameErr_q;
    slave_d = slave_q;
    mask_d = mask_q;
    rxData_d = rxData_q;
    if (sfrReq.wrEn && sfrReq.addr == ADDR_CONTROL)
    begin
      ctrl_d[BIT_MODE_LO:0] = sfrReq.wdata[BIT_MODE_LO:0]; // [RQ9]
      if (clkCfg.framingCheck)
      begin
        frameErr_d = sfrReq.wdata[BIT_MODE_HI]; // [RQ1] [RQ3]
      end
      else
      begin
        ctrl_d[BIT_MODE_HI] = sfrReq.wdata[BIT_MODE_HI]; // [RQ1]
      end
    end
    if (bitWr.en)
    begin
      if (bitWr.idx == 3'(BIT_MODE_HI) && clkCfg.framingCheck)
      begin
        frameErr_d = bitWr.val; // [RQ1] [RQ3]
      end
      else
      begin
        ctrl_d[bitWr.idx] = bitWr.val; // [RQ10]
      end
    end
    if (sfrReq.wrEn && sfrReq.addr == ADDR_SLAVE)
    begin
      slave_d = sfrReq.wdata;
    end
    if (sfrReq.wrEn && sfrReq.addr == ADDR_MASK)
    begin
      mask_d = sfrReq.wdata;
    end
    // Hardware sets win over a same-cycle software clear
    if (txDoneSet)
    begin
      ctrl_d[BIT_TXDONE] = 1'h1; // [RQ7]
    end
    if (rxFrameErr)
    begin
      frameErr_d = 1'h1; // [RQ2]
    end
    if (rxAccept && !ctrl_d[BIT_RXDONE])
    begin
      ctrl_d[BIT_RXDONE] = 1'h1; // [RQ8] [RQ12]
      rxData_d = rxByte; // [RQ16]
      if (rxLoadNinth)
      begin
        ctrl_d[BIT_RX9] = rxNinth; // [RQ6]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= RESET_CONTROL; // [RQ10]
      frameErr_q <= 1'h0;
      slave_q <= RESET_SLAVE;
      mask_q <= RESET_MASK;
      rxData_q <= RESET_BUFFER;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      frameErr_q <= frameErr_d;
      slave_q <= slave_d;
      mask_q <= mask_d;
      rxData_q <= rxData_d;
    end
  end

  // Transmitter
  always_comb
  begin
    txState_d = txState_q;
    txShift_d = txShift_q;
    txBits_d = txBits_q;
    txOvs_d = txOvs_q;
    txHalf_d = txHalf_q;
    txLine_d = txLine_q;
    txBit0_d = txBit0_q;
    txOe_d = txOe_q;
    txDoneSet = 1'h0;
    case (txState_q)
      TX_IDLE:
      begin
        if (txStart)
        begin
          txState_d = TX_SHIFT;
          txOvs_d = 4'h0;
          txHalf_d = 1'h0;
          txLine_d = 1'h0;
          if (mode == MODE_SHIFT)
          begin
            txShift_d = {3'h7, fifoData}; // [RQ4]
            txBits_d = M0_BITS;
            txBit0_d = fifoData[0];
            txOe_d = 1'h1;
          end
          else if (mode == MODE_UART8)
          begin
            txShift_d = {2'h3, fifoData, 1'h0};
            txBits_d = FRAME8_BITS;
          end
          else
          begin
            txShift_d = {1'h1, ctrl_q[BIT_TX9], fifoData, 1'h0}; // [RQ5]
            txBits_d = FRAME9_BITS;
          end
        end
      end
      TX_SHIFT:
      begin
        if (tick && mode == MODE_SHIFT)
        begin
          txHalf_d = ~txHalf_q;
          txLine_d = ~txHalf_q;
          if (txHalf_q)
          begin
            txShift_d = {1'h1, txShift_q[10:1]};
            txBits_d = txBits_q - 4'h1;
            txBit0_d = txShift_q[1];
            if (txBits_q == 4'h1)
            begin
              txDoneSet = 1'h1; // [RQ7]
              txState_d = TX_IDLE;
              txLine_d = 1'h1;
              txOe_d = 1'h0;
            end
          end
        end
        else if (tick)
        begin
          txOvs_d = txOvs_q + 4'h1;
          if (txOvs_q == OVS_LAST)
          begin
            txShift_d = {1'h1, txShift_q[10:1]};
            txBits_d = txBits_q - 4'h1;
            txLine_d = txShift_q[1];
            if (txBits_q == 4'h2)
            begin
              txDoneSet = 1'h1; // [RQ7]
            end
            if (txBits_q == 4'h1)
            begin
              txState_d = TX_IDLE;
            end
          end
        end
      end
      default:
      begin
        txState_d = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txState_q <= TX_IDLE;
      txShift_q <= '1;
      txBits_q <= 4'h0;
      txOvs_q <= 4'h0;
      txHalf_q <= 1'h0;
      txLine_q <= 1'h1;
      txBit0_q <= 1'h1;
      txOe_q <= 1'h0;
    end
    else
    begin
      txState_q <= txState_d;
      txShift_q <= txShift_d;
      txBits_q <= txBits_d;
      txOvs_q <= txOvs_d;
      txHalf_q <= txHalf_d;
      txLine_q <= txLine_d;
      txBit0_q <= txBit0_d;
      txOe_q <= txOe_d;
    end
  end

  // Receiver
  always_comb
  begin
    rxState_d = rxState_q;
    rxShift_d = rxShift_q;
    rxIdx_d = rxIdx_q;
    rxOvs_d = rxOvs_q;
    rxHalf_d = rxHalf_q;
    rxAccept = 1'h0;
    rxFrameErr = 1'h0;
    rxNinth = 1'h0;
    rxLoadNinth = 1'h0;
    case (rxState_q)
      RX_IDLE:
      begin
        if (ctrl_q[BIT_RX_EN] && mode == MODE_SHIFT)
        begin
          if (!ctrl_q[BIT_RXDONE] && txState_q == TX_IDLE && !fifoValid && tick)
          begin
            rxState_d = RX_SHIFT; // [RQ16]
            rxIdx_d = 4'h0;
            rxHalf_d = 1'h0;
          end
        end
        else if (ctrl_q[BIT_RX_EN] && rxdPrev_q && !rxdSync_q)
        begin
          rxState_d = RX_START; // [RQ16]
          rxOvs_d = 4'h0;
          rxIdx_d = 4'h0;
        end
      end
      RX_SHIFT:
      begin
        if (tick)
        begin
          rxHalf_d = ~rxHalf_q;
          if (!rxHalf_q)
          begin
            rxShift_d[rxIdx_q] = rxdSync_q;
          end
          else
          begin
            rxIdx_d = rxIdx_q + 4'h1;
            if (rxIdx_q == M0_BITS - 4'h1)
            begin
              rxAccept = 1'h1; // [RQ8]
              rxState_d = RX_IDLE;
            end
          end
        end
      end
      RX_START, RX_DATA:
      begin
        if (tick)
        begin
          rxOvs_d = rxOvs_q + 4'h1;
          if (rxOvs_q == OVS_MID && rxState_q == RX_START)
          begin
            rxState_d = rxdSync_q ? RX_IDLE : RX_DATA;
          end
          else if (rxOvs_q == OVS_MID && rxIdx_q != rxDataBits)
          begin
            rxShift_d[rxIdx_q] = rxdSync_q;
            rxIdx_d = rxIdx_q + 4'h1;
          end
          else if (rxOvs_q == OVS_MID)
          begin
            rxState_d = RX_IDLE;
            rxFrameErr = !rxdSync_q; // [RQ2]
            rxLoadNinth = 1'h1;
            rxNinth = (mode == MODE_UART8) ? rxdSync_q : rxShift_q[8]; // [RQ6]
            rxAccept = !multiActive || (rxNinth && (givenHit || bcastHit)); // [RQ12]
          end
        end
      end
      default:
      begin
        rxState_d = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxState_q <= RX_IDLE;
      rxShift_q <= '0;
      rxIdx_q <= 4'h0;
      rxOvs_q <= 4'h0;
      rxHalf_q <= 1'h0;
    end
    else
    begin
      rxState_q <= rxState_d;
      rxShift_q <= rxShift_d;
      rxIdx_q <= rxIdx_d;
      rxOvs_q <= rxOvs_d;
      rxHalf_q <= rxHalf_d;
    end
  end

  // Pins and read data
  always_comb
  begin
    case (sfrReq.addr)
      ADDR_CONTROL: sfrRdata_d = {clkCfg.framingCheck ? frameErr_q : ctrl_q[BIT_MODE_HI],
        ctrl_q[BIT_MODE_LO:0]}; // [RQ1]
      ADDR_BUFFER: sfrRdata_d = rxData_q; // [RQ16]
      ADDR_SLAVE: sfrRdata_d = slave_q;
      ADDR_MASK: sfrRdata_d = mask_q;
      default: sfrRdata_d = 8'h00;
    endcase
    txBufReady_d = fifoReady && !fifoPush;
    txd_d = (rxState_q == RX_SHIFT) ? rxHalf_q : txLine_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxdMeta_q <= 1'h1;
      rxdSync_q <= 1'h1;
      rxdPrev_q <= 1'h1;
      sfrRdata_q <= 8'h00;
      txBufReady_q <= 1'h0;
      txd_q <= 1'h1;
      rxdDrive_q <= 1'h1;
      rxdDriveEn_q <= 1'h0;
    end
    else
    begin
      rxdMeta_q <= rxdPin;
      rxdSync_q <= rxdMeta_q;
      rxdPrev_q <= rxdSync_q;
      sfrRdata_q <= sfrRdata_d;
      txBufReady_q <= txBufReady_d;
      txd_q <= txd_d;
      rxdDrive_q <= txBit0_q;
      rxdDriveEn_q <= txOe_q;
    end
  end

  assign sfrRdata = sfrRdata_q;
  assign txBufReady = txBufReady_q;
  assign txd = txd_q;
  assign rxdDrive = rxdDrive_q;
  assign rxdDriveEn = rxdDriveEn_q;
endmodule : spcr_top

// >>> dv/spcr_top_properties.sv
`timescale 1ns/100ps
module spcr_top_properties
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire spcr_pkg::spcr_sfr_req_t sfrReq,
  input wire spcr_pkg::spcr_bit_wr_t bitWr,
  input wire spcr_pkg::spcr_clkcfg_t clkCfg,
  input wire logic [7:0] sfrRdata,
  input wire logic txBufReady,
  input wire logic txd,
  input wire logic rxdDriveEn
);
  import spcr_pkg::*;
  logic [1:0] modeQ;
  logic [1:0] modeD;
  logic [7:0] slaveQ;
  logic [7:0] slaveD;
  logic mapped;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Shadow of the mode bits and slave address, from bus writes and bit writes
  always_comb
  begin
    modeD = modeQ;
    slaveD = slaveQ;
    if (sfrReq.wrEn && sfrReq.addr == ADDR_SLAVE)
      slaveD = sfrReq.wdata;
    if (sfrReq.wrEn && sfrReq.addr == ADDR_CONTROL)
    begin
      modeD[0] = sfrReq.wdata[BIT_MODE_LO];
      if (!clkCfg.framingCheck)
        modeD[1] = sfrReq.wdata[BIT_MODE_HI];
    end
    if (bitWr.en && bitWr.idx == 3'(BIT_MODE_LO))
      modeD[0] = bitWr.val;
    if (bitWr.en && bitWr.idx == 3'(BIT_MODE_HI) && !clkCfg.framingCheck)
      modeD[1] = bitWr.val;
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeQ <= 2'h0;
      slaveQ <= RESET_SLAVE;
    end
    else
    begin
      modeQ <= modeD;
      slaveQ <= slaveD;
    end
  end
  assign mapped = sfrReq.addr inside {ADDR_CONTROL, ADDR_BUFFER, ADDR_SLAVE, ADDR_MASK};
  sequence s_m0Std;
    !txd [*6] ##1 txd [*6];
  endsequence
  sequence s_m0Fast;
    !txd [*3] ##1 txd [*3];
  endsequence
  property p_m0Std;
    $fell(txd) && modeQ == 2'h0 && !clkCfg.halfCycle |-> s_m0Std;
  endproperty
  property p_m0Fast;
    $fell(txd) && modeQ == 2'h0 && clkCfg.halfCycle |-> s_m0Fast;
  endproperty
  property p_m2Low;
    $fell(txd) && modeQ == 2'h2 && !clkCfg.doubleRate |-> !txd throughout (##63 1'b1);
  endproperty
  property p_bufPush;
    sfrReq.wrEn && sfrReq.addr == ADDR_BUFFER && txBufReady |=> !txBufReady;
  endproperty
  property p_unmapped;
    !mapped |=> sfrRdata == 8'h00;
  endproperty
  property p_slaveRead;
    sfrReq.addr == ADDR_SLAVE && !sfrReq.wrEn |=> sfrRdata == slaveQ;
  endproperty
  property p_driveMode0;
    rxdDriveEn |-> modeQ == 2'h0;
  endproperty
  property p_readyAfterReset;
    $rose(rst_n) |=> txBufReady;
  endproperty
  a_m0Std: assert property (p_m0Std) else $error("mode 0 clock not 12");
  a_m0Fast: assert property (p_m0Fast) else $error("mode 0 clock not 6");
  a_m2Low: assert property (p_m2Low) else $error("mode 2 bit short");
  a_bufPush: assert property (p_bufPush) else $error("push not taken");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_slaveRead: assert property (p_slaveRead) else $error("slave readback");
  a_driveMode0: assert property (p_driveMode0) else $error("drive outside mode 0");
  a_readyAfterReset: assert property (p_readyAfterReset) else $error("not ready");
endmodule : spcr_top_properties

bind spcr_top spcr_top_properties i_spcr_top_properties (.sys_clk(sys_clk), .rst_n(rst_n),
  .sfrReq(sfrReq), .bitWr(bitWr), .clkCfg(clkCfg), .sfrRdata(sfrRdata),
  .txBufReady(txBufReady), .txd(txd), .rxdDriveEn(rxdDriveEn));

// >>> dv/spcr_remote_node.sv
`timescale 1ns/100ps
// Remote node on the serial line, fixed-rate 9-bit frames
module spcr_remote_node
#(
  parameter int BIT_CLKS = 64
)
(
  input wire logic sys_clk,
  input wire logic txd,
  input wire logic rxdDrive,
  output logic lineOut
);
  initial lineOut = 1'b1;
  // Start, data LSB first, ninth bit, stop; line idles high
  task automatic sendFrame(input logic [8:0] d, input logic stopBit);
    logic [10:0] f;
    f = {stopBit, d, 1'b0};
    @(posedge sys_clk);
    for (int i = 0; i < 11; i++)
    begin
      lineOut <= f[i];
      repeat (BIT_CLKS) @(posedge sys_clk);
    end
    lineOut <= 1'b1;
  endtask : sendFrame
  task automatic recvFrame(output logic [9:0] d, output logic ok);
    ok = 1'b0;
    d = 10'h000;
    for (int c = 0; c < 2000 && !ok; c++)
    begin
      @(posedge sys_clk);
      ok = !txd;
    end
    repeat (BIT_CLKS / 2) @(posedge sys_clk);
    for (int i = 0; i < 10; i++)
    begin
      repeat (BIT_CLKS) @(posedge sys_clk);
      d[i] = txd;
    end
  endtask : recvFrame
  // Mode 0: data taken at each rising edge of the shift clock
  task automatic shiftIn(output logic [7:0] d);
    int n;
    logic p;
    n = 0;
    p = 1'b1;
    d = 8'h00;
    for (int c = 0; c < 400 && n < 8; c++)
    begin
      @(posedge sys_clk);
      if (txd && !p)
      begin
        d[n] = rxdDrive;
        n++;
      end
      p = txd;
    end
  endtask : shiftIn
endmodule : spcr_remote_node

// >>> dv/serial_port_control_regs_tb.sv
`timescale 1ns/100ps
module serial_port_control_regs_tb;
  import spcr_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  spcr_sfr_req_t sfrReq = '0;
  spcr_bit_wr_t bitWr = '0;
  spcr_clkcfg_t clkCfg = '0;
  logic baudTick = 1'b0;
  logic [1:0] tickCnt = 2'h0;
  logic [7:0] sfrRdata;
  logic txBufReady, txd, rxdDrive, rxdDriveEn, nodeLine, rxdPin;
  logic [7:0] regAddr [5] = '{ADDR_CONTROL, ADDR_BUFFER, ADDR_SLAVE, ADDR_MASK, 8'h55};
  logic [8:0] mpAddr [3] = '{9'h100, 9'h1f4, 9'h1ff};
  int fail_count = 0;
  int checks_done = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    tickCnt <= tickCnt + 2'h1;
    baudTick <= tickCnt == 2'h0;
  end
  // Device drives the data line in mode 0 transmit, else the node
  assign rxdPin = rxdDriveEn ? rxdDrive : nodeLine;
  spcr_top i_spcr_top (.sys_clk(sys_clk), .rst_n(rst_n), .sfrReq(sfrReq), .bitWr(bitWr),
    .clkCfg(clkCfg), .baudTick(baudTick), .rxdPin(rxdPin), .sfrRdata(sfrRdata),
    .txBufReady(txBufReady), .txd(txd), .rxdDrive(rxdDrive), .rxdDriveEn(rxdDriveEn));
  spcr_remote_node i_spcr_remote_node (.sys_clk(sys_clk), .txd(txd), .rxdDrive(rxdDrive),
    .lineOut(nodeLine));
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] want);
    checks_done++;
    if (seen !== want)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfrReq <= '{wrEn: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk);
    sfrReq.wrEn <= 1'b0;
  endtask : regWrite
  task automatic bitWrite(input logic [2:0] i, input logic v);
    @(posedge sys_clk);
    bitWr <= '{en: 1'b1, idx: i, val: v};
    @(posedge sys_clk);
    bitWr.en <= 1'b0;
  endtask : bitWrite
  task automatic checkReg(input string what, input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] want);
    logic [7:0] d;
    @(posedge sys_clk);
    sfrReq.addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    d = sfrRdata & m;
    check(what, {4'h0, d}, {4'h0, want});
  endtask : checkReg
  task automatic summarize();
    $display("Checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    summarize();
  end
  initial
  begin
    logic [9:0] f;
    logic [7:0] d;
    logic ok;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    foreach (regAddr[i]) checkReg("reset", regAddr[i], 8'hff, 8'h00);
    regWrite(ADDR_SLAVE, 8'hf1);
    regWrite(ADDR_MASK, 8'hfa);
    regWrite(8'h55, 8'hff);
    checkReg("slave", ADDR_SLAVE, 8'hff, 8'hf1);
    checkReg("mask", ADDR_MASK, 8'hff, 8'hfa);
    checkReg("unmapped", 8'h55, 8'hff, 8'h00);
    // Mode 2 transmit, ninth bit set
    regWrite(ADDR_CONTROL, 8'h88);
    regWrite(ADDR_BUFFER, 8'h5a);
    i_spcr_remote_node.recvFrame(f, ok);
    check("txframe", {1'b0, ok, f}, 12'h75a);
    checkReg("txdone", ADDR_CONTROL, 8'hff, 8'h8a);
    bitWrite(3'(BIT_TXDONE), 1'b0);
    checkReg("txclr", ADDR_CONTROL, 8'h02, 8'h00);
    // Mode 2 receive, then framing errors
    regWrite(ADDR_CONTROL, 8'h90);
    i_spcr_remote_node.sendFrame(9'h1c3, 1'b1);
    checkReg("rxdata", ADDR_BUFFER, 8'hff, 8'hc3);
    checkReg("rxctl", ADDR_CONTROL, 8'hff, 8'h95);
    bitWrite(3'(BIT_RXDONE), 1'b0);
    clkCfg.framingCheck <= 1'b1;
    i_spcr_remote_node.sendFrame(9'h012, 1'b0);
    checkReg("fe", ADDR_CONTROL, 8'h80, 8'h80);
    bitWrite(3'(BIT_RXDONE), 1'b0);
    i_spcr_remote_node.sendFrame(9'h034, 1'b1);
    checkReg("fekeep", ADDR_CONTROL, 8'h85, 8'h81);
    bitWrite(3'(BIT_MODE_HI), 1'b0);
    checkReg("feclr", ADDR_CONTROL, 8'h80, 8'h00);
    @(posedge sys_clk);
    clkCfg.framingCheck <= 1'b0;
    checkReg("modehi", ADDR_CONTROL, 8'hc0, 8'h80);
    // Address recognition: miss, given match, broadcast match
    regWrite(ADDR_CONTROL, 8'hb0);
    foreach (mpAddr[i])
    begin
      bitWrite(3'(BIT_RXDONE), 1'b0);
      i_spcr_remote_node.sendFrame(mpAddr[i], 1'b1);
      checkReg("mpdone", ADDR_CONTROL, 8'h01, (i > 0) ? 8'h01 : 8'h00);
    end
    checkReg("mpdata", ADDR_BUFFER, 8'hff, 8'hff);
    // Mode 3 transmit on every baud tick
    @(posedge sys_clk);
    clkCfg.doubleRate <= 1'b1;
    regWrite(ADDR_CONTROL, 8'hc0);
    regWrite(ADDR_BUFFER, 8'ha5);
    i_spcr_remote_node.recvFrame(f, ok);
    check("m3frame", {1'b0, ok, f}, 12'h6a5);
    // Mode 0 transmit at both shift rates
    for (int h = 0; h < 2; h++)
    begin
      @(posedge sys_clk);
      clkCfg.halfCycle <= h[0];
      regWrite(ADDR_CONTROL, 8'h00);
      fork
        regWrite(ADDR_BUFFER, 8'h3c);
        i_spcr_remote_node.shiftIn(d);
      join
      check("m0data", {4'h0, d}, 12'h03c);
      repeat (M0_DIV_STD) @(posedge sys_clk);
      checkReg("m0done", ADDR_CONTROL, 8'h03, 8'h02);
    end
    // Mode 0 receive, multiprocessor bit has no effect
    regWrite(ADDR_CONTROL, 8'h30);
    repeat (M0_DIV_STD * 16) @(posedge sys_clk);
    checkReg("m0rx", ADDR_CONTROL, 8'h3f, 8'h31);
    summarize();
  end
endmodule : serial_port_control_regs_tb
